// file: scsdr_checker.sv
// port-level checks for the serial port register block.
// assumes binding onto scsdr_top; sees only its ports.
`timescale 1ns/10ps
module scsdr_checker
(
    input wire        clk,
    input wire        nrst,
    input wire        psel,
    input wire        penable,
    input wire [11:0] paddr,
    input wire        pready,
    input wire        pslverr,
    input wire        sclk_out,
    input wire        sclk_oe,
    input wire        mosi_out,
    input wire        mosi_oe,
    input wire        miso_out,
    input wire        miso_oe,
    input wire        ss_n_in,
    input wire        pullup_en,
    input wire        pins_owned,
    input wire        ss_owned
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // bus phases, used to build the wait-state check
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    a_one_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
        else $error("access did not end after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_err_decode: assert property (pready |-> pslverr == !(paddr == 12'h000
        || paddr == 12'h004 || paddr == 12'h008))
        else $error("error response does not match address decode");
    // guard on the past value: oe and pins_owned both follow en in the same cycle
    a_pins_free: assert property (!pins_owned && !$past(pins_owned) |->
        !sclk_oe && !mosi_oe && !miso_oe)
        else $error("pin driven while port disabled");
    a_open_drain: assert property (!pullup_en && !$past(pullup_en) |->
        !(sclk_oe && sclk_out) && !(mosi_oe && mosi_out) && !(miso_oe && miso_out))
        else $error("open-drain pin driven high");
    a_one_driver: assert property (!(mosi_oe && miso_oe))
        else $error("both data lines driven at once");
    a_slave_float: assert property ((ss_owned && !mosi_oe && ss_n_in) [*3] |-> !miso_oe)
        else $error("deselected slave drives its data output");
    a_fault_stop: assert property (ss_owned && sclk_oe && $fell(ss_n_in) |->
        ##[1:3] !pins_owned)
        else $error("master kept pins after select fell");
endmodule
bind scsdr_top scsdr_checker chk_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .sclk_out(sclk_out),
    .sclk_oe(sclk_oe), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_out(miso_out),
    .miso_oe(miso_oe), .ss_n_in(ss_n_in), .pullup_en(pullup_en),
    .pins_owned(pins_owned), .ss_owned(ss_owned));

// file: scsdr_defs.vh
// constants shared by the serial port register block: offsets, bit
// positions, reset values and rate divisors.
// assumes inclusion by bare name from every design file that needs it.
//
// Overview of operation
// - rx enable plus full flag raises request
// - master select bit 1 master, resets 1
// - polarity bit sets idle clock level, resets 0
// - phase bit picks edge timing, resets 1
// - wired-or bit makes pins open-drain
// - enable bit on; clearing gives partial reset
// - partial reset empties tx, aborts, clears shifter
// - tx enable plus empty flag raises request
// - completed byte into receive register sets full
// - full clears by status then data read
// - error enable gates overflow and fault requests
// - byte while full sets overflow, keeps old
// - overflow clears by status then data read
// - slave select rising mid-transfer sets fault
// - master sees select falling, sets fault
// - fault clears by status read, control write
// - handing byte to shifter sets tx empty
// - writing transmit data clears tx empty
// - fault enable gates fault flag and master-mode select ownership
// - rate field divides clock 2,8,32,128
// - data address splits tx and rx registers
// - one byte each way per eight clocks
// - deselected slave floats output, ignores clock
`ifndef SCSDR_DEFS_VH
`define SCSDR_DEFS_VH
// register byte offsets
`define SCSDR_OFF_CTRL   12'h000
`define SCSDR_OFF_STAT   12'h004
`define SCSDR_OFF_DATA   12'h008
// control register bits
`define SCSDR_C_RIE      7
`define SCSDR_C_MSTR     5
`define SCSDR_C_CPOL     4
`define SCSDR_C_CPHA     3
`define SCSDR_C_WOM      2
`define SCSDR_C_EN       1
`define SCSDR_C_TIE      0
`define SCSDR_CTRL_RST   8'h28
`define SCSDR_CTRL_MASK  8'hbf
// status and control register bits
`define SCSDR_S_RXF      7
`define SCSDR_S_ERROR_IRQ_ENABLE    6
`define SCSDR_S_OVR      5
`define SCSDR_S_MODE_FAULT_FLAG     4
`define SCSDR_S_TXE      3
`define SCSDR_S_FAULT_DETECT_ENABLE   2
`define SCSDR_S_RHI      1
`define SCSDR_S_RLO      0
`define SCSDR_STAT_RST   8'h00
`define SCSDR_STAT_MASK  8'h47
// master rate divisors, bus clocks per serial clock
`define SCSDR_BD0        8'd2
`define SCSDR_BD1        8'd8
`define SCSDR_BD2        8'd32
`define SCSDR_BD3        8'd128
// serial clock edges per byte, counted from zero
`define SCSDR_LAST_EDGE  4'd15
`define SCSDR_EDGE_RST   4'd0
`define SCSDR_BYTE_RST   8'h00
`define SCSDR_PAD        24'h000000
`define SCSDR_WORD_RST   32'h00000000
`endif

// file: scsdr_edge.v
// edge detector: one flop of history, rising and falling pulses.
// assumes the input is already synchronous to clk.
`timescale 1ns/10ps
`include "scsdr_defs.vh"
module scsdr_edge
#(
    parameter RST_VAL = 1'b0        // history value after reset
)
(
    input  wire clk,
    input  wire nrst,
    input  wire sig,                // watched level
    output wire rise,               // sig went 0 to 1
    output wire fall                // sig went 1 to 0
);
    reg prev_q;                     // level seen one clock ago

    // history flop, synchronous reset
    always @(posedge clk)
    begin
        if (!nrst)
            prev_q <= RST_VAL;
        else
            prev_q <= sig;
    end

    assign rise = sig & ~prev_q;
    assign fall = ~sig & prev_q;
endmodule

// file: scsdr_peer.sv
// far-side slave model: 16-bit shifter, either clock phase, idle level learnt.
// assumes clock and data lines already resolved and synchronous to clk.
`timescale 1ns/10ps
module scsdr_peer
(
    input  wire        clk,
    input  wire        sclk,
    input  wire        mosi,
    input  wire        sel_n,
    input  wire        ph0,         // far side uses phase 0 timing
    input  wire [15:0] tx_word,
    output reg         miso_q = 1'b0,
    output reg  [15:0] rx_q = 16'h0000
);
    reg        sclk_q = 1'b0;   // last seen clock level
    reg        idle_q = 1'b0;   // clock level learnt while deselected
    reg [15:0] sh_q = 16'h0000; // outgoing bits, msb first
    // phase 1 drives on leading edges and samples on trailing ones;
    // phase 0 the other way round, first bit set up while deselected
    always @(posedge clk)
    begin
        sclk_q <= sclk;
        if (sel_n)
        begin
            idle_q <= sclk;
            sh_q   <= ph0 ? {tx_word[14:0], 1'b0} : tx_word;
            miso_q <= ph0 ? tx_word[15] : ~miso_q; // phase 1 toggles: no stale bit
        end
        else if (sclk != sclk_q && (sclk ^ idle_q) != ph0)
        begin
            miso_q <= sh_q[15];
            sh_q   <= {sh_q[14:0], 1'b0};
        end
        else if (sclk != sclk_q)
            rx_q <= {rx_q[14:0], mosi};
    end
endmodule

// file: scsdr_rate.v
// half-period timer for the master serial clock.
// assumes half is held stable while run is high.
`timescale 1ns/10ps
`include "scsdr_defs.vh"
module scsdr_rate
#(
    parameter CW = 8                // counter width
)
(
    input  wire          clk,
    input  wire          nrst,
    input  wire          run,       // count while high, else restart
    input  wire [CW-1:0] half,      // bus clocks per half period
    output wire          tick       // one-cycle pulse per half period
);
    reg  [CW-1:0] cnt_q;            // position inside half period
    wire [CW-1:0] lim;              // last count before the tick

    assign lim  = half - {{(CW-1){1'b0}}, 1'b1};
    assign tick = run & (cnt_q == lim);

    // restart on every stop so each byte starts a full half period
    always @(posedge clk)
    begin
        if (!nrst || !run || tick)
            cnt_q <= {CW{1'b0}};
        else
            cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
    end
endmodule

// file: scsdr_top.v
// byte-wide full-duplex serial port with control, status and data
// registers behind an APB slave.
// assumes pins arrive synchronous to clk; pad logic resolves out/oe.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "scsdr_defs.vh"
module scsdr_top
(
    input  wire        clk,
    input  wire        nrst,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // serial pins
    input  wire        sclk_in,
    output reg         sclk_out,
    output reg         sclk_oe,
    input  wire        mosi_in,
    output reg         mosi_out,
    output reg         mosi_oe,
    input  wire        miso_in,
    output reg         miso_out,
    output reg         miso_oe,
    input  wire        ss_n_in,
    // pad control and cpu request
    output reg         pullup_en,
    output reg         pins_owned,
    output reg         ss_owned,
    output reg         irq
);
    // register state
    reg  [7:0] ctrl_q;              // control register
    reg  [7:0] sctl_q;              // writable bits of status register
    reg        rxf_q;               // receive data full
    reg        ovr_q;               // overflow
    reg        mode_fault_flag_q;              // mode fault
    reg        txe_q;               // transmit data empty
    reg        arm_rx_q;            // status read saw full set
    reg        arm_ovr_q;           // status read saw overflow set
    reg        arm_mode_fault_flag_q;          // status read saw fault set
    reg  [7:0] tx_q;                // transmit data register
    reg  [7:0] rx_q;                // receive data register
    // shifter state
    reg  [7:0] sr_q;                // shift register, msb on the wire
    reg        samp_q;              // last sampled input bit
    reg  [3:0] edge_q;              // serial clock edge index
    reg        busy_q;              // byte in flight
    reg        mclk_q;              // master serial clock level

    // decoded control bits
    wire en     = ctrl_q[`SCSDR_C_EN];
    wire mstr   = ctrl_q[`SCSDR_C_MSTR];
    wire cpol   = ctrl_q[`SCSDR_C_CPOL];
    wire cpha   = ctrl_q[`SCSDR_C_CPHA];
    wire wom    = ctrl_q[`SCSDR_C_WOM];
    wire fault_detect_enable = sctl_q[`SCSDR_S_FAULT_DETECT_ENABLE];
    wire [1:0] rate = {sctl_q[`SCSDR_S_RHI], sctl_q[`SCSDR_S_RLO]};

    // apb phases: one wait state, then completion
    wire req     = psel & penable & ~pready;
    wire done    = psel & penable & pready;
    wire hit_c   = (paddr == `SCSDR_OFF_CTRL);
    wire hit_s   = (paddr == `SCSDR_OFF_STAT);
    wire hit_d   = (paddr == `SCSDR_OFF_DATA);
    wire mapped  = hit_c | hit_s | hit_d;
    wire wr_c    = done & pwrite & hit_c;
    wire wr_s    = done & pwrite & hit_s;
    wire wr_d    = done & pwrite & hit_d;
    wire rd_s    = req & ~pwrite & hit_s;     // arm on the cycle the read view is taken
    wire rd_d    = done & ~pwrite & hit_d;

    // status read view
    wire [7:0] stat_rd = sctl_q
                       | ({7'h00, rxf_q}  << `SCSDR_S_RXF)
                       | ({7'h00, ovr_q}  << `SCSDR_S_OVR)
                       | ({7'h00, mode_fault_flag_q} << `SCSDR_S_MODE_FAULT_FLAG)
                       | ({7'h00, txe_q}  << `SCSDR_S_TXE);

    // master divider selection, half period in bus clocks
    reg  [7:0] div_sel;             // selected divisor
    always @*
    begin
        case (rate)
            2'b00:   div_sel = `SCSDR_BD0;
            2'b01:   div_sel = `SCSDR_BD1;
            2'b10:   div_sel = `SCSDR_BD2;
            default: div_sel = `SCSDR_BD3;
        endcase
    end
    wire [7:0] half = {1'b0, div_sel[7:1]};

    // mode and select decode
    wire run_m   = en & mstr;
    wire sel_s   = en & ~mstr & ~ss_n_in;
    wire m_tick;                    // master half-period pulse
    wire sck_r;                     // slave clock rising
    wire sck_f;                     // slave clock falling
    wire ss_r;                      // select rising
    wire ss_f;                      // select falling

    scsdr_rate #(.CW(8)) u_rate
    (
        .clk  (clk),
        .nrst (nrst),
        .run  (run_m & busy_q),
        .half (half),
        .tick (m_tick)
    );

    scsdr_edge #(.RST_VAL(1'b0)) u_sck
    (
        .clk  (clk),
        .nrst (nrst),
        .sig  (sclk_in),
        .rise (sck_r),
        .fall (sck_f)
    );

    scsdr_edge #(.RST_VAL(1'b1)) u_ss
    (
        .clk  (clk),
        .nrst (nrst),
        .sig  (ss_n_in),
        .rise (ss_r),
        .fall (ss_f)
    );

    // one edge stream for both modes; a deselected slave sees none
    wire s_edge  = sel_s & (sck_r | sck_f);
    wire sc_edge = run_m ? (m_tick & busy_q) : s_edge;
    wire in_bit  = mstr ? miso_in : mosi_in;
    // even edges lead; phase picks whether they sample or shift
    wire smp_e   = (edge_q[0] == cpha);
    wire last_e  = (edge_q == `SCSDR_LAST_EDGE);
    wire [7:0] byte_in = cpha ? {sr_q[6:0], in_bit}
                              : {sr_q[6:0], samp_q};
    wire fin     = sc_edge & last_e;
    wire m_start = run_m & ~busy_q & ~txe_q;
    wire s_load  = en & ~mstr & ~busy_q & ~txe_q;
    wire load    = m_start | s_load;
    // faults, gated by the port enable and the detect enable
    wire f_slave = en & ~mstr & fault_detect_enable & busy_q & ss_r;
    wire f_mast  = run_m & fault_detect_enable & ss_f;
    wire fault   = f_slave | f_mast;

    // control register; a master fault drops the enable
    always @(posedge clk)
    begin
        if (!nrst)
            ctrl_q <= `SCSDR_CTRL_RST;
        else if (f_mast)
            ctrl_q <= ctrl_q & ~(8'h01 << `SCSDR_C_EN);
        else if (wr_c)
            ctrl_q <= pwdata[7:0] & `SCSDR_CTRL_MASK;
    end

    // writable status bits: error enable, fault enable, rate
    always @(posedge clk)
    begin
        if (!nrst)
            sctl_q <= `SCSDR_STAT_RST;
        else if (wr_s)
            sctl_q <= pwdata[7:0] & `SCSDR_STAT_MASK;
    end

    // arming for the two-step clear sequences
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            arm_rx_q   <= 1'b0;
            arm_ovr_q  <= 1'b0;
            arm_mode_fault_flag_q <= 1'b0;
        end
        else
        begin
            if (rd_s)
            begin
                arm_rx_q  <= rxf_q;
                arm_ovr_q <= ovr_q;
            end
            else if (rd_d)
            begin
                arm_rx_q  <= 1'b0;
                arm_ovr_q <= 1'b0;
            end
            if (rd_s)
                arm_mode_fault_flag_q <= mode_fault_flag_q;
            else if (wr_c)
                arm_mode_fault_flag_q <= 1'b0;
        end
    end

    // receive flags; a new event beats a clear in the same cycle
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            rxf_q <= 1'b0;
            ovr_q <= 1'b0;
            rx_q  <= `SCSDR_BYTE_RST;
        end
        else if (fin && rxf_q && !(rd_d && arm_rx_q))
        begin
            ovr_q <= 1'b1;
        end
        else if (fin)
        begin
            rx_q  <= byte_in;
            rxf_q <= 1'b1;
            if (rd_d && arm_ovr_q)
                ovr_q <= 1'b0;
        end
        else if (rd_d)
        begin
            if (arm_rx_q)
                rxf_q <= 1'b0;
            if (arm_ovr_q)
                ovr_q <= 1'b0;
        end
    end

    // mode fault flag, cleared by control write after armed read
    always @(posedge clk)
    begin
        if (!nrst)
            mode_fault_flag_q <= 1'b0;
        else if (fault)
            mode_fault_flag_q <= 1'b1;
        else if (wr_c && arm_mode_fault_flag_q)
            mode_fault_flag_q <= 1'b0;
    end

    // transmit data register and empty flag
    // software must only write while empty; a write otherwise
    // overwrites the pending byte
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            txe_q <= 1'b1;
            tx_q  <= `SCSDR_BYTE_RST;
        end
        else
        begin
            if (wr_d)
                tx_q <= pwdata[7:0];
            if (!en || load)
                txe_q <= 1'b1;
            else if (wr_d)
                txe_q <= 1'b0;
        end
    end

    // shifter: load, sample, shift, finish, abort
    always @(posedge clk)
    begin
        if (!nrst || !en)
        begin
            sr_q   <= `SCSDR_BYTE_RST;
            samp_q <= 1'b0;
            edge_q <= `SCSDR_EDGE_RST;
            busy_q <= 1'b0;
        end
        else if (!mstr && ss_n_in)
        begin
            // deselect aborts a slave byte even mid-transfer
            edge_q <= `SCSDR_EDGE_RST;
            busy_q <= 1'b0;
            if (s_load)
                sr_q <= tx_q;
        end
        else if (load)
        begin
            sr_q   <= tx_q;
            edge_q <= `SCSDR_EDGE_RST;
            busy_q <= mstr;
        end
        else if (sc_edge)
        begin
            busy_q <= ~last_e;
            edge_q <= last_e ? `SCSDR_EDGE_RST : edge_q + 4'd1;
            // the closing edge leaves the last bit standing on the wire
            if (smp_e && !last_e)
                samp_q <= in_bit;
            else if (!smp_e && !last_e && !(cpha && edge_q == `SCSDR_EDGE_RST))
                sr_q <= {sr_q[6:0], samp_q};
            if (!mstr && edge_q == `SCSDR_EDGE_RST)
                busy_q <= 1'b1;
        end
    end

    // master serial clock: idles at polarity, toggles per half period
    always @(posedge clk)
    begin
        if (!nrst)
            mclk_q <= 1'b0;
        else if (!busy_q || !run_m)
            mclk_q <= cpol;
        else if (m_tick)
            mclk_q <= ~mclk_q;
    end

    // pins: open-drain drives only lows, push-pull drives both
    wire d_sck  = run_m;
    wire d_mosi = run_m;
    wire d_miso = sel_s;
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            sclk_out   <= 1'b0;
            sclk_oe    <= 1'b0;
            mosi_out   <= 1'b0;
            mosi_oe    <= 1'b0;
            miso_out   <= 1'b0;
            miso_oe    <= 1'b0;
            pullup_en  <= 1'b1;
            pins_owned <= 1'b0;
            ss_owned   <= 1'b0;
        end
        else
        begin
            sclk_out   <= ~wom & mclk_q;
            sclk_oe    <= d_sck & (~wom | ~mclk_q);
            mosi_out   <= ~wom & sr_q[7];
            mosi_oe    <= d_mosi & (~wom | ~sr_q[7]);
            miso_out   <= ~wom & sr_q[7];
            miso_oe    <= d_miso & (~wom | ~sr_q[7]);
            pullup_en  <= ~wom;
            pins_owned <= en;
            ss_owned   <= en & (~mstr | fault_detect_enable);
        end
    end

    // cpu request: level, follows flags and enables
    always @(posedge clk)
    begin
        if (!nrst)
            irq <= 1'b0;
        else
            irq <= (ctrl_q[`SCSDR_C_RIE] & rxf_q)
                 | (ctrl_q[`SCSDR_C_TIE] & txe_q)
                 | (sctl_q[`SCSDR_S_ERROR_IRQ_ENABLE] & (ovr_q | mode_fault_flag_q));
    end

    // apb answer: ready one cycle into the access phase
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `SCSDR_WORD_RST;
        end
        else
        begin
            pready  <= req;
            pslverr <= req & ~mapped;
            if (req && !pwrite && hit_c)
                prdata <= {`SCSDR_PAD, ctrl_q};
            else if (req && !pwrite && hit_s)
                prdata <= {`SCSDR_PAD, stat_rd};
            else if (req && !pwrite && hit_d)
                prdata <= {`SCSDR_PAD, rx_q};
            else if (req)
                prdata <= `SCSDR_WORD_RST;
        end
    end
endmodule

// file: test_spi_control_status_data_regs.sv
// self-checking bench for the serial port register block.
// assumes scsdr_top, scsdr_peer and the bound checker.
`timescale 1ns/10ps
`include "scsdr_defs.vh"
module test_spi_control_status_data_regs;
    localparam logic [11:0] a_ctl = `SCSDR_OFF_CTRL;
    localparam logic [11:0] a_sts = `SCSDR_OFF_STAT;
    localparam logic [11:0] a_dat = `SCSDR_OFF_DATA;
    logic        clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic        err, ss_n_in = 1, peer_sel_n = 1, peer_ph0 = 0;
    logic [15:0] peer_tx = 0;
    wire  [31:0] prdata;
    wire  [15:0] peer_rx;
    wire         pready, pslverr, sclk_out, sclk_oe, mosi_out, mosi_oe, miso_w;
    wire         miso_out, miso_oe, pullup_en, pins_owned, ss_owned, irq;
    int          err_count = 0, n_tests = 0, cyc = 0;
    // released lines float high through the pullups
    wire sclk_w = sclk_oe ? sclk_out : 1'b1;
    wire mosi_w = mosi_oe ? mosi_out : 1'b1;
    scsdr_top dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclk_in(sclk_w), .sclk_out(sclk_out),
        .sclk_oe(sclk_oe), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
        .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n_in),
        .pullup_en(pullup_en), .pins_owned(pins_owned), .ss_owned(ss_owned), .irq(irq));
    scsdr_peer peer_u (.clk(clk), .sclk(sclk_w), .mosi(mosi_w), .sel_n(peer_sel_n),
        .ph0(peer_ph0), .tx_word(peer_tx), .miso_q(miso_w), .rx_q(peer_rx));
    initial
    begin
        forever #5 clk = ~clk;
    end
    task finish_test;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            err_count++;
            finish_test;
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer; request held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        // waits as long as the slave needs; only the bench timeout ends it
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
        @(posedge clk);
    endtask
    task rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(nm, e, rd);
    endtask
    // polls status until the given flag bit reads set
    task wflag(input int b);
        int n;
        n = 0;
        rd = 0;
        while (rd[b] !== 1'b1 && n < 300)
        begin
            apb(0, a_sts, 0);
            n++;
        end
        chk("flag wait", 1, rd[b]);
    endtask
    task t_reset;
        rchk("ctrl reset", a_ctl, 32'h28);
        rchk("stat reset", a_sts, 32'h08);
        apb(0, 12'h00c, 0);
        chk("slverr", 1, err);
        apb(1, a_ctl, 32'hff);
        @(posedge clk);
        chk("irq tx", 1, irq);
        chk("pullup", 0, pullup_en);
        chk("owned", 1, pins_owned);
        rchk("ctrl rw", a_ctl, 32'hbf);
        apb(1, a_sts, 32'hff);
        rchk("stat rw", a_sts, 32'h4f);
        apb(1, a_sts, 0);
        apb(1, a_ctl, 32'h28);
        $display("test reset done");
    endtask
    task t_xfer;
        int n;
        apb(1, a_ctl, 32'haa);
        peer_tx <= 16'ha55a;
        apb(1, a_sts, 32'h01);
        peer_sel_n <= 0;
        apb(1, a_dat, 32'h3c);
        n = 0;
        while (sclk_out !== 1'b1 && n < 100)
        begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (sclk_out === 1'b1 && n < 100)
        begin
            @(posedge clk);
            n++;
        end
        chk("half period", 4, n);
        wflag(7);
        chk("irq rx", 1, irq);
        chk("peer rx", 32'h3c, {24'h0, peer_rx[7:0]});
        rchk("rx data", a_dat, 32'ha5);
        rchk("stat clr", a_sts, 32'h09);
        chk("irq off", 0, irq);
        peer_sel_n <= 1;
        $display("test transfer done");
    endtask
    // phase 0 with idle-high clock; select is toggled around the byte
    task t_ph0;
        apb(1, a_ctl, 32'hb2);
        peer_tx <= 16'hc381; peer_ph0 <= 1;
        apb(1, a_sts, 32'h01);
        peer_sel_n <= 0;
        apb(1, a_dat, 32'h96);
        wflag(7);
        chk("sclk idle", 1, sclk_out);
        chk("peer rx ph0", 32'h96, {24'h0, peer_rx[7:0]});
        rchk("rx data ph0", a_dat, 32'hc3);
        peer_sel_n <= 1; peer_ph0 <= 0;
        $display("test phase 0 done");
    endtask
    task t_ovr;
        apb(1, a_ctl, 32'h2e);
        peer_tx <= 16'h1122;
        apb(1, a_sts, 32'h41);
        peer_sel_n <= 0;
        apb(1, a_dat, 32'h66);
        apb(1, a_dat, 32'h77);
        rchk("tx busy", a_sts, 32'h41);
        wflag(5);
        chk("stat ovr", 32'he9, rd);
        chk("irq err", 1, irq);
        chk("pullup", 0, pullup_en);
        rchk("rx old", a_dat, 32'h11);
        chk("peer rx", 32'h6677, {16'h0, peer_rx});
        rchk("ovr clr", a_sts, 32'h49);
        peer_sel_n <= 1;
        $display("test overflow done");
    endtask
    task t_fault;
        apb(1, a_ctl, 32'h2a);
        apb(1, a_sts, 32'h04);
        ss_n_in <= 0;
        repeat (3) @(posedge clk);
        chk("owned", 0, pins_owned);
        rchk("stat mf", a_sts, 32'h1c);
        rchk("ctrl off", a_ctl, 32'h28);
        ss_n_in <= 1;
        apb(1, a_sts, 0);
        rchk("mf kept", a_sts, 32'h18);
        apb(1, a_ctl, 32'h28);
        rchk("mf clr", a_sts, 32'h08);
        $display("test fault done");
    endtask
    task t_abort;
        apb(1, a_ctl, 32'h2a);
        apb(1, a_sts, 32'h03);
        peer_sel_n <= 0;
        apb(1, a_dat, 32'h5a);
        repeat (50) @(posedge clk);
        apb(1, a_ctl, 32'h28);
        @(posedge clk);
        chk("owned", 0, pins_owned);
        rchk("stat abort", a_sts, 32'h0b);
        apb(1, a_ctl, 32'h2a);
        repeat (1100) @(posedge clk);
        rchk("no resume", a_sts, 32'h0b);
        peer_sel_n <= 1;
        $display("test abort done");
    endtask
    task t_slave;
        apb(1, a_ctl, 32'h0b);
        repeat (4) @(posedge clk);
        chk("miso float", 0, miso_oe);
        chk("irq tx", 1, irq);
        chk("ss owned", 1, ss_owned);
        ss_n_in <= 0;
        repeat (4) @(posedge clk);
        chk("miso drive", 1, miso_oe);
        ss_n_in <= 1;
        apb(1, a_ctl, 32'h28);
        $display("test slave done");
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        t_reset;
        t_xfer;
        t_ph0;
        t_ovr;
        t_fault;
        t_abort;
        t_slave;
        finish_test;
    end
endmodule
